// File: src/fsbp_regs.vh
// constants for the status register and block protection logic
// assumes a serial host in clock mode 0 and 4-byte addressing
`ifndef FSBP_REGS_VH
`define FSBP_REGS_VH

// ==========================================================
// command opcodes
`define FSBP_OP_WREN 8'h06
`define FSBP_OP_WRDI 8'h04
`define FSBP_OP_RDSR 8'h05
`define FSBP_OP_WRSR 8'h01
`define FSBP_OP_RDFSR 8'h70
`define FSBP_OP_CLFSR 8'h50
`define FSBP_OP_PROG 8'h12
`define FSBP_OP_SE64 8'hDC
`define FSBP_OP_SE32 8'h5C
`define FSBP_OP_SE4 8'h21
`define FSBP_OP_DIE 8'hC4

// ==========================================================
// status register fields
`define FSBP_SR_RESET 8'h00
`define FSBP_SR_SRWD 7
`define FSBP_SR_PROTECT_SEL_MSB 6
`define FSBP_SR_TB 5
`define FSBP_SR_PROT_HI 4
`define FSBP_SR_PROTECT_SEL_LSB 2
`define FSBP_SR_WEL 1
`define FSBP_SR_WIP 0
`define FSBP_SR_NV_MASK 8'hFC

// ==========================================================
// flag status register fields
`define FSBP_FS_RESET 8'h00
`define FSBP_FS_READY 7
`define FSBP_FS_ERASE_ERR 5
`define FSBP_FS_PROG_ERR 4
`define FSBP_FS_PROT_ERR 1

// ==========================================================
// address map and protection limits
`define FSBP_SECT_HI 26
`define FSBP_SECT_LO 16
`define FSBP_PROT_ALL 4'hC
`define FSBP_ADDR_BYTES 4

// ==========================================================
// operation kinds on the array port
`define FSBP_KIND_WRSR 3'h0
`define FSBP_KIND_PROG 3'h1
`define FSBP_KIND_SE64 3'h2
`define FSBP_KIND_SE32 3'h3
`define FSBP_KIND_SE4 3'h4
`define FSBP_KIND_DIE 3'h5

// ==========================================================
// default busy time in core cycles
`define FSBP_BUSY_CYC 1000

`endif

// File: src/fsbp_core.v
// serial status register, write enable latch and block protection
// assumes pins are asynchronous to i_core_clk and the serial clock
// is far slower than the core clock; array timing is a busy counter
`timescale 1ns/1ps
`include "fsbp_regs.vh"

// Summary of operation
// - read-status returns the status byte; write-status updates it
// - disable bit set and write-protect pin low blocks write-status
// - bit 7 is the nonvolatile write-disable bit, default 0
// - bit 5 selects top (0, default) or bottom (1) protection
// - block-protect field is bit 6 then bits 4 to 2
// - program and erase into a protected sector are refused
// - top mode: value n protects highest 2^(n-1) sectors, 12+ all
// - write-enable latch is cleared at reset
// - write-enable command must precede write-status, program, erase
// - bit 0 reads busy during write-status, program or erase
// - bit 0 is always the inverse of flag status bit 7
// - die erase runs only when the block-protect field is zero
// - 2048 sectors of 64KB with 32KB and 4KB subsectors
// - flag status bit 7 reads 0 busy and 1 ready
// - protected program or erase sets flag bit 1 until cleared
module fsbp_core #(
	parameter BUSY_CYCLES = `FSBP_BUSY_CYC,
	parameter ADDR_W = 32
) (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_sck,
	input wire i_cs_n,
	input wire i_si,
	input wire i_wp_n,
	output reg o_so,
	output reg o_so_oe,
	output reg [7:0] o_status,
	output reg [7:0] o_flag_status,
	output reg o_op_start,
	output reg [2:0] o_op_kind,
	output reg [ADDR_W-1:0] o_op_addr,
	output reg [7:0] o_op_data
);

// ==========================================================
// pin synchronisers
reg [2:0] sck_sync_reg;
reg [2:0] cs_sync_reg;
reg [1:0] si_sync_reg;
reg [1:0] wp_sync_reg;

always @(posedge i_core_clk) begin
	if (!i_rst_n) begin
		sck_sync_reg <= 3'h0;
		cs_sync_reg <= 3'h7;
		si_sync_reg <= 2'h0;
		wp_sync_reg <= 2'h0;
	end else begin
		sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
		cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
		si_sync_reg <= {si_sync_reg[0], i_si};
		wp_sync_reg <= {wp_sync_reg[0], i_wp_n};
	end
end

wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
wire cs_act = ~cs_sync_reg[1];
wire cs_end = cs_sync_reg[1] & ~cs_sync_reg[2];
wire si_bit = si_sync_reg[1];
wire wp_low = ~wp_sync_reg[1];

// ==========================================================
// registers
reg [7:0] sr_nv_reg;
reg wel_reg;
reg busy_reg;
reg [7:0] fs_err_reg;
reg [31:0] busy_cnt_reg;
reg [2:0] bit_cnt_reg;
reg [7:0] in_sh_reg;
reg [7:0] op_reg;
reg [3:0] byte_cnt_reg;
reg [ADDR_W-1:0] addr_reg;
reg [7:0] data_reg;
reg [7:0] out_sh_reg;
reg [7:0] pend_sr_reg;
reg [2:0] pend_kind_reg;

wire [7:0] status_now = {sr_nv_reg[7:2], wel_reg, busy_reg};
wire [7:0] flag_now = {~busy_reg, fs_err_reg[6:0]};
wire [7:0] in_byte = {in_sh_reg[6:0], si_bit};

// ==========================================================
// block protection decode
wire [3:0] block_protect_field = {sr_nv_reg[`FSBP_SR_PROTECT_SEL_MSB],
	sr_nv_reg[`FSBP_SR_PROT_HI:`FSBP_SR_PROTECT_SEL_LSB]};
wire tb_bottom = sr_nv_reg[`FSBP_SR_TB];
wire [10:0] sector = addr_reg[`FSBP_SECT_HI:`FSBP_SECT_LO];
wire [3:0] prot_m1 = block_protect_field - 4'h1;
wire [11:0] prot_size = 12'h001 << prot_m1;
wire [11:0] sect_top = {1'b0, ~sector};
wire [11:0] sect_bot = {1'b0, sector};
reg sect_prot;

always @* begin
	if (block_protect_field == 4'h0) begin
		sect_prot = 1'b0;
	end else if (block_protect_field >= `FSBP_PROT_ALL) begin
		sect_prot = 1'b1;
	end else if (!tb_bottom) begin
		sect_prot = (sect_top < prot_size);
	end else begin
		sect_prot = (sect_bot < prot_size);
	end
end

wire hw_locked = sr_nv_reg[`FSBP_SR_SRWD] & wp_low;

// ==========================================================
// command classification at end of frame
wire is_arr = (op_reg == `FSBP_OP_PROG) | (op_reg == `FSBP_OP_SE64) |
	(op_reg == `FSBP_OP_SE32) | (op_reg == `FSBP_OP_SE4);
wire arr_full = (byte_cnt_reg > `FSBP_ADDR_BYTES);
reg [2:0] arr_kind;

always @* begin
	case (op_reg)
	`FSBP_OP_PROG: arr_kind = `FSBP_KIND_PROG;
	`FSBP_OP_SE64: arr_kind = `FSBP_KIND_SE64;
	`FSBP_OP_SE32: arr_kind = `FSBP_KIND_SE32;
	`FSBP_OP_SE4: arr_kind = `FSBP_KIND_SE4;
	default: arr_kind = `FSBP_KIND_DIE;
	endcase
end

wire rd_op = (op_reg == `FSBP_OP_RDSR) | (op_reg == `FSBP_OP_RDFSR);

// ==========================================================
// serial shifter
always @(posedge i_core_clk) begin
	if (!i_rst_n) begin
		bit_cnt_reg <= 3'h0;
		in_sh_reg <= 8'h00;
		op_reg <= 8'h00;
		byte_cnt_reg <= 4'h0;
		addr_reg <= {ADDR_W{1'b0}};
		data_reg <= 8'h00;
		out_sh_reg <= 8'h00;
		o_so <= 1'b0;
		o_so_oe <= 1'b0;
	end else if (!cs_act) begin
		bit_cnt_reg <= 3'h0;
		byte_cnt_reg <= 4'h0;
		o_so_oe <= 1'b0;
	end else begin
		if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			in_sh_reg <= in_byte;
			if (bit_cnt_reg == 3'h7) begin
				if (byte_cnt_reg != 4'hF) begin
					byte_cnt_reg <= byte_cnt_reg + 4'h1;
				end
				if (byte_cnt_reg == 4'h0) begin
					op_reg <= in_byte;
				end else if (byte_cnt_reg <= `FSBP_ADDR_BYTES) begin
					addr_reg <= {addr_reg[ADDR_W-9:0], in_byte};
				end
				if (byte_cnt_reg == 4'h1 ||
					byte_cnt_reg == 4'h5) begin
					data_reg <= in_byte;
				end
				if (byte_cnt_reg == 4'h0) begin
					if (in_byte == `FSBP_OP_RDFSR) begin
						out_sh_reg <= flag_now;
					end else begin
						out_sh_reg <= status_now;
					end
				end else if (op_reg == `FSBP_OP_RDFSR) begin
					out_sh_reg <= flag_now;
				end else begin
					out_sh_reg <= status_now;
				end
			end
		end
		if (sck_fall && byte_cnt_reg != 4'h0) begin
			o_so <= out_sh_reg[7];
			out_sh_reg <= {out_sh_reg[6:0], 1'b0};
			o_so_oe <= rd_op;
		end
	end
end

// ==========================================================
// command execution, latch, busy and flags
always @(posedge i_core_clk) begin
	if (!i_rst_n) begin
		sr_nv_reg <= `FSBP_SR_RESET;
		wel_reg <= 1'b0;
		busy_reg <= 1'b0;
		fs_err_reg <= `FSBP_FS_RESET;
		busy_cnt_reg <= 32'h0;
		pend_sr_reg <= 8'h00;
		pend_kind_reg <= 3'h0;
		o_op_start <= 1'b0;
		o_op_kind <= 3'h0;
		o_op_addr <= {ADDR_W{1'b0}};
		o_op_data <= 8'h00;
	end else begin
		o_op_start <= 1'b0;
		if (busy_reg) begin
			if (busy_cnt_reg == 32'h0) begin
				busy_reg <= 1'b0;
				wel_reg <= 1'b0;
				if (pend_kind_reg == `FSBP_KIND_WRSR) begin
					sr_nv_reg <= pend_sr_reg & `FSBP_SR_NV_MASK;
				end
			end else begin
				busy_cnt_reg <= busy_cnt_reg - 32'h1;
			end
		end else if (cs_end && byte_cnt_reg != 4'h0) begin
			case (op_reg)
			`FSBP_OP_WREN: begin
				wel_reg <= 1'b1;
			end
			`FSBP_OP_WRDI: begin
				wel_reg <= 1'b0;
			end
			`FSBP_OP_CLFSR: begin
				fs_err_reg <= `FSBP_FS_RESET;
			end
			`FSBP_OP_WRSR: begin
				if (wel_reg && byte_cnt_reg >= 4'h2) begin
					if (hw_locked) begin
						wel_reg <= 1'b0;
					end else begin
						busy_reg <= 1'b1;
						busy_cnt_reg <= BUSY_CYCLES - 1;
						pend_sr_reg <= data_reg;
						pend_kind_reg <= `FSBP_KIND_WRSR;
					end
				end
			end
			`FSBP_OP_DIE: begin
				if (wel_reg) begin
					if (block_protect_field != 4'h0) begin
						wel_reg <= 1'b0;
						fs_err_reg[`FSBP_FS_PROT_ERR] <= 1'b1;
						fs_err_reg[`FSBP_FS_ERASE_ERR] <= 1'b1;
					end else begin
						busy_reg <= 1'b1;
						busy_cnt_reg <= BUSY_CYCLES - 1;
						pend_kind_reg <= `FSBP_KIND_DIE;
						o_op_start <= 1'b1;
						o_op_kind <= `FSBP_KIND_DIE;
						o_op_addr <= {ADDR_W{1'b0}};
					end
				end
			end
			default: begin
				if (is_arr && arr_full && wel_reg) begin
					if (sect_prot) begin
						wel_reg <= 1'b0;
						fs_err_reg[`FSBP_FS_PROT_ERR] <= 1'b1;
						if (op_reg == `FSBP_OP_PROG) begin
							fs_err_reg[`FSBP_FS_PROG_ERR] <= 1'b1;
						end else begin
							fs_err_reg[`FSBP_FS_ERASE_ERR] <= 1'b1;
						end
					end else begin
						busy_reg <= 1'b1;
						busy_cnt_reg <= BUSY_CYCLES - 1;
						pend_kind_reg <= arr_kind;
						o_op_start <= 1'b1;
						o_op_kind <= arr_kind;
						o_op_addr <= addr_reg;
						o_op_data <= data_reg;
					end
				end
			end
			endcase
		end
	end
end

// ==========================================================
// registered status outputs
always @(posedge i_core_clk) begin
	if (!i_rst_n) begin
		o_status <= `FSBP_SR_RESET;
		o_flag_status <= 8'h80;
	end else begin
		o_status <= status_now;
		o_flag_status <= flag_now;
	end
end

endmodule // fsbp_core

// File: sim/fsbp_props.sv
// assertions on the status and protection block ports
// assumes a bind onto fsbp_core
`timescale 1ns/1ps
module fsbp_props #(
	parameter ADDR_W = 32
) (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_wp_n,
	input wire [7:0] o_status,
	input wire [7:0] o_flag_status,
	input wire o_op_start,
	input wire [2:0] o_op_kind,
	input wire [ADDR_W-1:0] o_op_addr
);
	// ==========================================
	// helpers
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	wire [3:0] prot_sel = {o_status[6], o_status[4:2]};
	wire [10:0] sec = o_op_addr[26:16];
	wire [11:0] span = 12'h001 << (prot_sel - 4'h1);
	wire hit = prot_sel >= 4'hC || (prot_sel != 4'h0 &&
		(o_status[5] ? sec < span : sec >= 12'h800 - span));
	sequence s_locked;
		(o_status[7] && !i_wp_n && !o_status[0]) [*4];
	endsequence
	sequence s_done;
		$fell(o_status[0]);
	endsequence
	busy_mirror_a: assert property (o_status[0] == !o_flag_status[7])
		else $error("busy bit not inverse of ready flag");
	prot_refuse_a: assert property (o_op_start && o_op_kind != 3'h5
		|-> !hit)
		else $error("operation started in protected sector");
	die_guard_a: assert property (o_op_start && o_op_kind == 3'h5
		|-> prot_sel == 4'h0)
		else $error("die erase started with protection set");
	start_busy_a: assert property (o_op_start |-> ##[0:3] o_status[0])
		else $error("no busy after operation start");
	wel_reset_a: assert property ($rose(i_rst_n) |-> !o_status[1])
		else $error("latch set out of reset");
	done_clear_a: assert property (s_done |-> !o_status[1])
		else $error("latch still set after busy end");
	nv_write_a: assert property ($changed(o_status[7:2]) |-> s_done)
		else $error("status bits changed outside a write");
	hw_lock_a: assert property (s_locked |=> $stable(o_status[7:2]))
		else $error("status changed while locked");
endmodule // fsbp_props

// File: sim/fsbp_host.sv
// host serial controller model, mode 0, msb first
// assumes a 32 ns serial clock that stops between frames
`timescale 1ns/1ps
module fsbp_host (
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si,
	input wire i_so
);
	// ==========================================
	// frame task
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	task automatic xfer(input logic [47:0] d, input int n,
		output logic [7:0] r);
		r = 8'h00;
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#8 o_si = d[i];
			#8 o_sck = 1'b1;
			#14 r = {r[6:0], i_so};
			#2 o_sck = 1'b0;
		end
		#16 o_cs_n = 1'b1;
		o_si = ~o_si;
		#40;
	endtask
endmodule // fsbp_host

// File: sim/testbench.sv
// self-checking bench for the status and protection block
// assumes the host model drives the serial pins
`timescale 1ns/1ps
module testbench;
	// ==========================================
	// signals and instances
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_wp_n = 1'b1;
	wire sck, cs_n, si, so, so_oe, op_start;
	wire [7:0] status, flags, op_data;
	wire [2:0] kind;
	wire [31:0] addr;
	logic [2:0] k_seen;
	logic [31:0] a_seen;
	logic [7:0] d_seen;
	logic [7:0] rd;
	logic [7:0] oc [5] = '{8'h12, 8'hDC, 8'h5C, 8'h21, 8'hC4};
	int n_mismatch = 0;
	int checks_done = 0;
	int starts = 0;
	always #2 i_core_clk = ~i_core_clk;
	fsbp_core #(.BUSY_CYCLES(20)) dut (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
		.i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .o_status(status),
		.o_flag_status(flags), .o_op_start(op_start), .o_op_kind(kind),
		.o_op_addr(addr), .o_op_data(op_data));
	fsbp_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
		.i_so(so_oe ? so : ~so));
	always @(posedge i_core_clk) begin
		if (op_start === 1'b1) begin
			starts++;
			k_seen <= kind;
			a_seen <= addr;
			d_seen <= op_data;
		end
	end
	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic rdsr();
		host.xfer({32'h0, 8'h05, 8'h00}, 16, rd);
	endtask
	task automatic idle();
		for (int i = 0; i < 40; i++) begin
			rdsr();
			if (rd[0] === 1'b0) return;
		end
		n_mismatch++;
		close_out();
	endtask
	task automatic wrsr(input logic [7:0] v);
		host.xfer(48'h06, 8, rd);
		host.xfer({32'h0, 8'h01, v}, 16, rd);
		idle();
	endtask
	function automatic logic prot(input int t, input int n, input int s);
		if (n == 0) return 1'b0;
		if (n >= 12) return 1'b1;
		return t ? s < (1 << (n - 1)) : s >= 2048 - (1 << (n - 1));
	endfunction
	task automatic op(input int k, input int s, input logic ok);
		int c;
		int b;
		logic [31:0] a;
		c = starts;
		b = k == 0 ? 48 : (k == 4 ? 8 : 40);
		a = {5'h00, s[10:0], 16'hF000};
		host.xfer(48'h06, 8, rd);
		host.xfer({oc[k], a, 8'hA5} >> (48 - b), b, rd);
		idle();
		chk(starts - c, ok);
		chk(flags[1], !ok);
		chk(status[1], 0);
		if (ok && k != 4) chk(a_seen, a);
		if (ok) chk(k_seen, k + 1);
		if (ok && k == 0) chk(d_seen, 8'hA5);
		host.xfer({32'h0, 8'h70, 8'h00}, 16, rd);
		chk(rd, ok ? 8'h80 : (k == 0 ? 8'h92 : 8'hA2));
		host.xfer(48'h50, 8, rd);
		chk(flags, 8'h80);
	endtask
	// ==========================================
	// sequence
	initial begin
		repeat (10) @(posedge i_core_clk);
		#1 i_rst_n = 1'b1;
		repeat (4) @(posedge i_core_clk);
		#1;
		chk(flags, 8'h80);
		rdsr();
		chk(rd, 8'h00);
		host.xfer({32'h0, 8'h01, 8'hFC}, 16, rd);
		rdsr();
		chk(rd, 8'h00);
		host.xfer(48'h06, 8, rd);
		rdsr();
		chk(rd, 8'h02);
		host.xfer(48'h04, 8, rd);
		rdsr();
		chk(rd, 8'h00);
		for (int t = 0; t < 2; t++) begin
			for (int n = 0; n < 16; n++) begin
				logic [3:0] p;
				int m;
				p = n;
				m = (n >= 1 && n <= 11) ? 1 << (n - 1) : 1024;
				m = t ? m - 1 : 2048 - m;
				wrsr({1'b0, p[3], t[0], p[2:0], 2'b00});
				rdsr();
				chk(rd, {1'b0, p[3], t[0], p[2:0], 2'b00});
				op(n % 4, m, !prot(t, n, m));
				op((n + 1) % 4, t ? m + 1 : m - 1,
					!prot(t, n, t ? m + 1 : m - 1));
				op(4, 0, n == 0);
			end
		end
		host.xfer(48'h06, 8, rd);
		host.xfer({32'h0, 8'h01, 8'h80}, 16, rd);
		chk(status[0], 1);
		idle();
		@(posedge i_core_clk);
		#1 i_wp_n = 1'b0;
		wrsr(8'h00);
		rdsr();
		chk(rd, 8'h80);
		@(posedge i_core_clk);
		#1 i_wp_n = 1'b1;
		wrsr(8'h00);
		rdsr();
		chk(rd, 8'h00);
		close_out();
	end
endmodule // testbench

bind fsbp_core fsbp_props #(.ADDR_W(ADDR_W)) u_props (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wp_n(i_wp_n),
	.o_status(o_status), .o_flag_status(o_flag_status),
	.o_op_start(o_op_start), .o_op_kind(o_op_kind), .o_op_addr(o_op_addr));
